/* File: hdl/ssfl_pkg.sv */
// package: register map, field positions and carrier types
package ssfl_pkg;

  // ---------------------------------------------------------------
  // register map (word offsets in bytes)
  // ---------------------------------------------------------------
  localparam logic [3:0] SSFL_OFS_STATUS  = 4'h0;
  localparam logic [3:0] SSFL_OFS_CONTROL = 4'h4;
  localparam logic [3:0] SSFL_OFS_RXDATA  = 4'h8;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int SSFL_B_TXEMPTY = 7;
  localparam int SSFL_B_RXFULL  = 6;
  localparam int SSFL_B_OVERRUN = 5;
  localparam int SSFL_B_FRAMING = 4;
  localparam int SSFL_B_PARITY  = 3;
  localparam int SSFL_B_TXEND   = 2;
  localparam int SSFL_B_RXMP    = 1;
  localparam int SSFL_B_TXMP    = 0;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int SSFL_C_RXEN   = 0;
  localparam int SSFL_C_TXEN   = 1;
  localparam int SSFL_C_SYNC   = 2;
  localparam int SSFL_C_PAREN  = 3;
  localparam int SSFL_C_PARODD = 4;
  localparam int SSFL_C_MP     = 5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SSFL_STATUS_RST  = 8'h84;
  localparam logic [7:0] SSFL_CONTROL_RST = 8'h00;
  localparam logic [7:0] SSFL_RXDATA_RST  = 8'h00;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       valid;      // one-cycle: character fully received
    logic [7:0] data;
    logic       stop1;      // first stop bit level
    logic       par_bit;
    logic       mp_bit;
  } ssfl_rx_char_t;

  typedef struct packed {
    logic       load;       // one-cycle: data register moved to shifter
    logic       last_bit;   // one-cycle: final bit of a character sent
  } ssfl_tx_evt_t;

  typedef enum logic [1:0] {
    SSFL_IDLE = 2'b01,
    SSFL_ACK  = 2'b10
  } ssfl_bus_t;

  typedef struct packed {
    ssfl_bus_t  bus;
    logic [7:0] status;
    logic [7:0] control;
    logic [7:0] rxdata;
    logic [7:0] seen_one;  // flag bits read as 1 since last write
    logic [7:0] dat;
  } ssfl_state_t;

endpackage : ssfl_pkg

/* File: hdl/ssfl_top.sv */
// serial channel status flag logic with a classic wishbone slave
`timescale 1ns/10ps
// Behaviour
// - on overrun the received data register keeps old byte; new byte dropped
// - no character accepted while overrun flag is one
// - clocked synchronous mode: overrun flag blocks transmission
// - asynchronous mode: stop bit zero sets framing flag
// - with two stop bits only the first one is checked
// - framing error stores byte, no full flag, stops receive, sync stops send
// - framing, parity flags clear by reset, standby, read-one-write-zero
// - clearing receive enable leaves framing and parity flags as they were
// - asynchronous parity mismatch against even/odd setting sets parity flag
// - parity error stores byte, no full flag, halts receive, sync halts send
// - transmit end set when empty flag is one as last bit leaves
// - transmit end forced to one by reset, standby, transmit enable cleared
// - transmit end cleared by empty-flag zero write after read, or dma write
// - transmit end is read-only
// - multiprocessor receive bit captured, read-only
// - received multiprocessor bit holds when receive disabled; starts at zero
// - transmit multiprocessor bit appended in asynchronous mp mode
// - transmit multiprocessor bit ignored in sync, non-mp mode or when idle
// - error-free character sets receive full flag
// - writing one to status flags has no effect, except transmit mp bit, which takes the value written
module ssfl_top
  import ssfl_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    standby_i,
  // wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [3:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  // receive shifter side
  input  wire ssfl_pkg::ssfl_rx_char_t rx_char_i,
  output logic                         rx_accept_o,
  // transmit shifter side
  input  wire ssfl_pkg::ssfl_tx_evt_t  tx_evt_i,
  input  wire logic                    tx_active_i,
  output logic                         tx_allow_o,
  output logic                         tx_mp_bit_o,
  output logic                         tx_mp_en_o,
  // dma engine
  input  wire logic                    dma_tx_wr_i,
  input  wire logic                    dma_rx_rd_i,
  // status and control towards the channel
  output logic      [7:0]              status_o,
  output logic      [7:0]              control_o
);
  import ssfl_pkg::*;

  ssfl_state_t st_r;
  ssfl_state_t st_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic par_bad(input ssfl_rx_char_t c,
                                   input logic odd);
    par_bad = ((^c.data) ^ c.par_bit) != odd;
  endfunction : par_bad

  function automatic logic err_block(input logic [7:0] s);
    err_block = s[SSFL_B_OVERRUN] | s[SSFL_B_FRAMING] | s[SSFL_B_PARITY];
  endfunction : err_block

  // ---------------------------------------------------------------
  // combinational next state
  // ---------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       rd;
  logic       sync_m;
  logic       rx_ok;
  logic [7:0] clr;
  logic       fe;
  logic       pe;

  always_comb
  begin
    st_nxt = st_r;
    acc    = cyc_i && stb_i && (st_r.bus == SSFL_IDLE);
    wr     = acc && we_i && sel_i[0];
    rd     = acc && !we_i;
    sync_m = st_r.control[SSFL_C_SYNC];
    clr    = 8'h00;
    fe     = 1'b0;
    pe     = 1'b0;
    // receive enabled and no error flag pending
    rx_ok  = st_r.control[SSFL_C_RXEN] && !err_block(st_r.status);

    // ---- bus handshake ----
    unique case (st_r.bus)
      SSFL_IDLE:
      begin
        if (acc)
        begin
          st_nxt.bus = SSFL_ACK;
        end
      end
      SSFL_ACK:
      begin
        st_nxt.bus = SSFL_IDLE;
      end
    endcase

    if (rd)
    begin
      unique case (adr_i)
        SSFL_OFS_STATUS:
        begin
          st_nxt.dat      = st_r.status;
          st_nxt.seen_one = st_r.seen_one | st_r.status;
        end
        SSFL_OFS_CONTROL: st_nxt.dat = st_r.control;
        SSFL_OFS_RXDATA:  st_nxt.dat = st_r.rxdata;
        default:          st_nxt.dat = 8'h00;
      endcase
    end

    if (wr && adr_i == SSFL_OFS_CONTROL)
    begin
      st_nxt.control = dat_i[7:0];
    end

    // flags 7..3 clear only on zero written over a bit seen as one
    if (wr && adr_i == SSFL_OFS_STATUS)
    begin
      clr = ~dat_i[7:0] & st_r.seen_one & 8'hF8;
      st_nxt.status[SSFL_B_TXMP] = dat_i[SSFL_B_TXMP];
      st_nxt.seen_one = 8'h00;
    end

    // ---- software/dma clears ----
    if (clr[SSFL_B_TXEMPTY])
    begin
      st_nxt.status[SSFL_B_TXEMPTY] = 1'b0;
      st_nxt.status[SSFL_B_TXEND]   = 1'b0;
    end
    if (dma_tx_wr_i)
    begin
      st_nxt.status[SSFL_B_TXEMPTY] = 1'b0;
      st_nxt.status[SSFL_B_TXEND]   = 1'b0;
    end
    if (clr[SSFL_B_RXFULL] || dma_rx_rd_i)
    begin
      st_nxt.status[SSFL_B_RXFULL] = 1'b0;
    end
    if (clr[SSFL_B_OVERRUN])
    begin
      st_nxt.status[SSFL_B_OVERRUN] = 1'b0;
    end
    if (clr[SSFL_B_FRAMING])
    begin
      st_nxt.status[SSFL_B_FRAMING] = 1'b0;
    end
    if (clr[SSFL_B_PARITY])
    begin
      st_nxt.status[SSFL_B_PARITY] = 1'b0;
    end

    // ---- transmit events: sets win over clears ----
    if (tx_evt_i.load)
    begin
      st_nxt.status[SSFL_B_TXEMPTY] = 1'b1;
    end
    if (tx_evt_i.last_bit && st_r.status[SSFL_B_TXEMPTY])
    begin
      st_nxt.status[SSFL_B_TXEND] = 1'b1;
    end

    // ---- receive events ----
    if (rx_char_i.valid && rx_ok)
    begin
      if (st_r.status[SSFL_B_RXFULL])
      begin
        // keep old byte, the new one is lost
        st_nxt.status[SSFL_B_OVERRUN] = 1'b1;
      end
      else
      begin
        fe = !sync_m && !rx_char_i.stop1;
        pe = !sync_m && st_r.control[SSFL_C_PAREN]
             && par_bad(rx_char_i, st_r.control[SSFL_C_PARODD]);
        st_nxt.rxdata = rx_char_i.data;
        if (fe)
        begin
          st_nxt.status[SSFL_B_FRAMING] = 1'b1;
        end
        if (pe)
        begin
          st_nxt.status[SSFL_B_PARITY] = 1'b1;
        end
        if (!fe && !pe)
        begin
          st_nxt.status[SSFL_B_RXFULL] = 1'b1;
        end
        if (!sync_m && st_r.control[SSFL_C_MP])
        begin
          st_nxt.status[SSFL_B_RXMP] = rx_char_i.mp_bit;
        end
      end
    end
    // receive-enable low touches no error or mp flag

    // transmit disabled forces empty and end
    if (!st_nxt.control[SSFL_C_TXEN])
    begin
      st_nxt.status[SSFL_B_TXEMPTY] = 1'b1;
      st_nxt.status[SSFL_B_TXEND]   = 1'b1;
    end

    if (standby_i)
    begin
      st_nxt.status   = SSFL_STATUS_RST;
      st_nxt.seen_one = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r.bus      <= SSFL_IDLE;
      st_r.status   <= SSFL_STATUS_RST;
      st_r.control  <= SSFL_CONTROL_RST;
      st_r.rxdata   <= SSFL_RXDATA_RST;
      st_r.seen_one <= 8'h00;
      st_r.dat      <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ack_o       = (st_r.bus == SSFL_ACK);
  assign dat_o       = {24'h000000, st_r.dat};
  assign rx_accept_o = st_r.control[SSFL_C_RXEN] && !err_block(st_r.status);
  // sync mode: any error flag stops the sender too
  assign tx_allow_o  = st_r.control[SSFL_C_TXEN]
                       && !(st_r.control[SSFL_C_SYNC]
                            && err_block(st_r.status));
  assign tx_mp_en_o  = !st_r.control[SSFL_C_SYNC] && st_r.control[SSFL_C_MP]
                       && tx_active_i;
  assign tx_mp_bit_o = tx_mp_en_o && st_r.status[SSFL_B_TXMP];
  assign status_o    = st_r.status;
  assign control_o   = st_r.control;

endmodule : ssfl_top

/* File: sim/ssfl_props.sv */
// checker: port-level properties of the status flag block
`timescale 1ns/10ps
module ssfl_props
  import ssfl_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          standby_i,
  input wire logic          cyc_i,
  input wire logic          stb_i,
  input logic               ack_o,
  input wire ssfl_rx_char_t rx_char_i,
  input logic               rx_accept_o,
  input wire ssfl_tx_evt_t  tx_evt_i,
  input wire logic          tx_active_i,
  input logic               tx_allow_o,
  input logic               tx_mp_bit_o,
  input logic               tx_mp_en_o,
  input wire logic          dma_tx_wr_i,
  input logic [7:0]         status_o,
  input logic [7:0]         control_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_RX_BLOCK: assert property (
    rx_accept_o == (control_o[0] && !(|status_o[5:3])))
    else $error("receive accept wrong");
  AST_TX_BLOCK: assert property (
    tx_allow_o == (control_o[1] && !(control_o[2] && |status_o[5:3])))
    else $error("transmit allow wrong");
  AST_OVERRUN: assert property (
    rx_char_i.valid && rx_accept_o && status_o[6] |=> status_o[5])
    else $error("overrun not flagged");
  AST_FRAMING: assert property (
    rx_char_i.valid && rx_accept_o && !control_o[2] && !rx_char_i.stop1
    && !status_o[6] |=> status_o[4] && !status_o[6])
    else $error("framing error not flagged");
  AST_TRANSMIT_END_FLAG_SET: assert property (
    tx_evt_i.last_bit && status_o[7] && control_o[1] && !dma_tx_wr_i
    |=> status_o[2])
    else $error("transmit end not set");
  AST_TE_OFF: assert property (
    !control_o[1] ##1 !control_o[1] |-> status_o[7] && status_o[2])
    else $error("empty and end not forced");
  AST_STANDBY: assert property (standby_i |=> status_o == 8'h84)
    else $error("standby did not reset status");
  AST_RXMP_HOLD: assert property (
    !control_o[0] && !standby_i |=> $stable(status_o[1]))
    else $error("received mp bit changed");
  AST_TXMP: assert property (
    (tx_mp_en_o == (!control_o[2] && control_o[5] && tx_active_i))
    && (tx_mp_bit_o == (tx_mp_en_o && status_o[0])))
    else $error("transmit mp bit wrong");
endmodule : ssfl_props
bind ssfl_top ssfl_props u_props(.clk_i, .rst_i, .standby_i, .cyc_i,
  .stb_i, .ack_o, .rx_char_i, .rx_accept_o, .tx_evt_i, .tx_active_i,
  .tx_allow_o, .tx_mp_bit_o, .tx_mp_en_o, .dma_tx_wr_i, .status_o,
  .control_o);

/* File: sim/ssfl_peer.sv */
// partner: receive and transmit shifter events of the far station
`timescale 1ns/10ps
module ssfl_peer
  import ssfl_pkg::*;
(
  input  wire logic clk_i,
  output ssfl_rx_char_t rx_char_o,
  output ssfl_tx_evt_t  tx_evt_o,
  output logic          tx_active_o
);
  initial rx_char_o = {1'b0, 8'h5A, 3'b010};
  initial tx_evt_o = 2'b00;
  initial tx_active_o = 1'b0;
  // released data lines show the inverse, never a stale copy
  task automatic send(input logic [7:0] d, input logic s, p, m);
    @(posedge clk_i);
    rx_char_o <= {1'b1, d, s, p, m};
    @(posedge clk_i);
    rx_char_o <= {1'b0, ~d, ~s, ~p, ~m};
  endtask : send
  task automatic xmit();
    @(posedge clk_i);
    tx_active_o <= 1'b1;
    tx_evt_o <= 2'b10;
    @(posedge clk_i);
    tx_evt_o <= 2'b00;
    @(posedge clk_i);
    tx_evt_o <= 2'b01;
    @(posedge clk_i);
    tx_evt_o <= 2'b00;
    tx_active_o <= 1'b0;
  endtask : xmit
endmodule : ssfl_peer

/* File: sim/testbench.sv */
// testbench: wishbone driven sequences over the status flag block
`timescale 1ns/10ps
module testbench;
  import ssfl_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          standby_i = 1'b0;
  logic          cyc_i = 1'b0;
  logic          stb_i = 1'b0;
  logic          we_i = 1'b0;
  logic [3:0]    adr_i = 4'h0;
  logic [3:0]    sel_i = 4'hF;
  logic [31:0]   dat_i = 32'h0;
  logic          dma_tx_wr_i = 1'b0;
  logic          dma_rx_rd_i = 1'b0;
  logic [31:0]   dat_o, q;
  logic [7:0]    status_o, control_o;
  logic          ack_o, rx_accept_o, tx_allow_o, tx_mp_bit_o, tx_mp_en_o;
  logic          tx_active_i;
  ssfl_rx_char_t rx_char_i;
  ssfl_tx_evt_t  tx_evt_i;
  int            fail_count = 0;
  int            num_checks = 0;
  ssfl_top uut(.clk_i, .rst_i, .standby_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .rx_char_i, .rx_accept_o, .tx_evt_i,
    .tx_active_i, .tx_allow_o, .tx_mp_bit_o, .tx_mp_en_o, .dma_tx_wr_i,
    .dma_rx_rd_i, .status_o, .control_o);
  ssfl_peer peer(.clk_i, .rx_char_o(rx_char_i), .tx_evt_o(tx_evt_i),
    .tx_active_o(tx_active_i));
  initial forever #5 clk_i = ~clk_i;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // one request at a time; the watchdog ends a hung wait
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : bus
  task automatic st(input logic [7:0] e);
    bus(1'b0, SSFL_OFS_STATUS, 8'h00, q);
    chk("status", q, {24'h0, e});
  endtask : st
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (6000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    st(8'h84);
    bus(1'b0, SSFL_OFS_CONTROL, 8'h00, q);
    chk("control", q, 32'h0);
    bus(1'b0, 4'hC, 8'h00, q);
    chk("unmapped", q, 32'h0);
    wr(SSFL_OFS_STATUS, 8'hFF);
    st(8'h85);
    $display("test registers done");
    wr(SSFL_OFS_CONTROL, 8'h2B);
    @(posedge clk_i);
    dma_tx_wr_i <= 1'b1;
    @(posedge clk_i);
    dma_tx_wr_i <= 1'b0;
    st(8'h01);
    fork
      peer.xmit();
      begin
        repeat (2) @(posedge clk_i);
        chk("tx_mp_bit", {31'h0, tx_mp_bit_o}, 32'h1);
        chk("tx_mp_en", {31'h0, tx_mp_en_o}, 32'h1);
      end
    join
    st(8'h85);
    chk("tx_mp_idle", {31'h0, tx_mp_en_o}, 32'h0);
    wr(SSFL_OFS_STATUS, 8'h00);
    st(8'h00);
    $display("test transmit done");
    peer.send(8'hA5, 1'b1, 1'b0, 1'b1);
    st(8'h42);
    peer.send(8'h3C, 1'b1, 1'b0, 1'b1);
    st(8'h62);
    chk("rx_accept", {31'h0, rx_accept_o}, 32'h0);
    bus(1'b0, SSFL_OFS_RXDATA, 8'h00, q);
    chk("rxdata", q, 32'hA5);
    peer.send(8'h00, 1'b0, 1'b0, 1'b1);
    st(8'h62);
    wr(SSFL_OFS_STATUS, 8'h00);
    st(8'h02);
    $display("test overrun done");
    peer.send(8'h0F, 1'b0, 1'b0, 1'b1);
    bus(1'b0, SSFL_OFS_RXDATA, 8'h00, q);
    chk("rxdata", q, 32'h0F);
    wr(SSFL_OFS_STATUS, 8'h00);
    wr(SSFL_OFS_CONTROL, 8'h2A);
    st(8'h12);
    wr(SSFL_OFS_STATUS, 8'h00);
    st(8'h02);
    wr(SSFL_OFS_CONTROL, 8'h2B);
    peer.send(8'h01, 1'b1, 1'b0, 1'b1);
    st(8'h0A);
    wr(SSFL_OFS_STATUS, 8'h00);
    wr(SSFL_OFS_CONTROL, 8'h3B);
    peer.send(8'h01, 1'b1, 1'b0, 1'b1);
    st(8'h42);
    @(posedge clk_i);
    dma_rx_rd_i <= 1'b1;
    @(posedge clk_i);
    dma_rx_rd_i <= 1'b0;
    st(8'h02);
    // clocked synchronous mode: no framing check, errors stop the sender
    wr(SSFL_OFS_CONTROL, 8'h07);
    chk("tx_allow", {31'h0, tx_allow_o}, 32'h1);
    peer.send(8'h55, 1'b0, 1'b1, 1'b0);
    st(8'h42);
    peer.send(8'h66, 1'b0, 1'b1, 1'b0);
    st(8'h62);
    chk("tx_allow", {31'h0, tx_allow_o}, 32'h0);
    wr(SSFL_OFS_STATUS, 8'h00);
    chk("tx_allow", {31'h0, tx_allow_o}, 32'h1);
    $display("test errors done");
    wr(SSFL_OFS_CONTROL, 8'h39);
    st(8'h86);
    @(posedge clk_i);
    standby_i <= 1'b1;
    @(posedge clk_i);
    standby_i <= 1'b0;
    st(8'h84);
    $display("test standby done");
    test_done();
  end
endmodule : testbench
